// ==== ext_posing.sv ====
// External-input positioning command engine with an Avalon-MM register slave.
`timescale 1ns/100ps
`default_nettype none
`include "ext_posing_defines.svh"
module ext_posing #(
  parameter logic [31:0] SPEED_MAX = 32'h0010_0000,
  parameter logic [31:0] ACCEL_MAX = 32'h0001_0000,
  parameter logic [31:0] TORQUE_MAX = 32'h0000_FFFF
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire ext_posing_pkg::bus_req_t bus_in,
  output logic bus_waitrequest_out,
  output logic [31:0] bus_readdata_out,
  input wire logic servo_on_in,
  input wire logic [3:0] latch_signals_in,
  output ext_posing_pkg::drive_ref_t drive_ref_out,
  output logic irq_out
);
  import ext_posing_pkg::*;

  ext_state_t s_q;
  ext_state_t s_d;

  localparam logic [7:0] SETTLE_COUNT = 8'(`SETTLE_CYCLES);

  // Moves one step of at most mag toward tgt; the sign of the remaining distance sets the way.
  function automatic logic signed [31:0] step_toward(input logic signed [31:0] pos,
                                                      input logic signed [31:0] tgt,
                                                      input logic [31:0] mag);
    logic signed [32:0] diff;
    diff = 33'(tgt) - 33'(pos);
    if (diff >= 0) begin
      step_toward = (diff <= $signed({1'b0, mag})) ? tgt : 32'(pos + $signed(mag));
    end else begin
      step_toward = (-diff <= $signed({1'b0, mag})) ? tgt : 32'(pos - $signed(mag));
    end
  endfunction

  // Picks the word a monitor field reports.
  function automatic logic [31:0] monitor_word(input logic [7:0] sel, input ext_state_t s);
    case (sel)
      8'h00: monitor_word = s.pos;
      8'h01: monitor_word = s.tgt;
      8'h02: monitor_word = s.latched;
      8'h03: monitor_word = s.vel;
      8'h04: monitor_word = s.torque_ceiling_eff;
      default: monitor_word = 32'h0000_0000;
    endcase
  endfunction

  // Rate clamp: zero keeps the old rate, above the limit is cut and flagged.
  function automatic logic [32:0] rate_pick(input logic [31:0] req, input logic [31:0] cur);
    if (req == 32'h0000_0000) begin
      rate_pick = {1'b0, cur};
    end else if (req > ACCEL_MAX) begin
      rate_pick = {1'b1, ACCEL_MAX};
    end else begin
      rate_pick = {1'b0, req};
    end
  endfunction

  logic req_any;
  logic accept_cmd;
  logic latch_level;
  logic latch_edge;
  logic busy;
  logic [4:0] irq_set;
  logic [32:0] acc_pick;
  logic [32:0] dec_pick;

  assign req_any = bus_in.read | bus_in.write;
  assign bus_waitrequest_out = req_any & ~s_q.ack;
  assign bus_readdata_out = s_q.rdata;
  assign accept_cmd = bus_in.write & s_q.ack & (bus_in.address == `OFF_CMD)
      & (bus_in.writedata[7:0] == `CMD_CODE_EXTERNAL_POSITIONING_CMD);
  assign latch_level = latch_signals_in[s_q.latch_sel];
  assign latch_edge = latch_level & ~s_q.latch_prev;
  assign busy = (s_q.fsm == ST_MOVE_FIRST) | (s_q.fsm == ST_MOVE_FINAL);
  assign irq_out = |(s_q.irq_stat & s_q.irq_en);
  assign drive_ref_out.position = s_q.pos;
  assign drive_ref_out.velocity = s_q.vel;
  assign drive_ref_out.torque = s_q.torque_ceiling_eff;
  assign acc_pick = rate_pick(s_q.accel_rate_w, s_q.acc_eff);
  assign dec_pick = rate_pick(s_q.decel_rate_w, s_q.dec_eff);

  always_comb begin
    s_d = s_q;
    irq_set = 5'h00;
    s_d.ack = req_any & ~s_q.ack;
    s_d.latch_prev = latch_level;
    // Bus writes to configuration registers.
    if (bus_in.write & s_q.ack) begin
      case (bus_in.address)
        `OFF_CTRL: begin
          s_d.cancel = bus_in.writedata[`CTRL_CANCEL];
          s_d.latch_req = bus_in.writedata[`CTRL_LATCH_REQ];
          s_d.latch_sel = bus_in.writedata[`CTRL_LATCH_SEL_LO +: 2];
        end
        `OFF_TARGET_POSITION: s_d.target_position_w = bus_in.writedata;
        `OFF_TARGET_SPEED: s_d.target_speed_w = bus_in.writedata;
        `OFF_ACCEL_RATE: s_d.accel_rate_w = bus_in.writedata;
        `OFF_DECEL_RATE: s_d.decel_rate_w = bus_in.writedata;
        `OFF_TORQUE_CEILING: s_d.torque_ceiling_w = bus_in.writedata;
        `OFF_FINAL: s_d.final_w = bus_in.writedata;
        `OFF_MONSEL_A: s_d.monsel_a = bus_in.writedata[7:0];
        `OFF_MONSEL_B: s_d.monsel_b = bus_in.writedata[7:0];
        `OFF_IRQ_EN: s_d.irq_en = bus_in.writedata[4:0];
        `OFF_IRQ_CLR: s_d.irq_stat = s_q.irq_stat & ~bus_in.writedata[4:0];
        default: s_d.ack = s_d.ack;
      endcase
    end
    // Read data is latched at the acknowledge so it stands at the edge waitrequest is low.
    if (bus_in.read & ~s_q.ack) begin
      case (bus_in.address)
        `OFF_CMD: s_d.rdata = {24'h00_0000, s_q.resp_code};
        `OFF_CTRL: s_d.rdata = {28'h000_0000, s_q.latch_sel, s_q.latch_req, s_q.cancel};
        `OFF_TARGET_POSITION: s_d.rdata = s_q.target_position_w;
        `OFF_TARGET_SPEED: s_d.rdata = s_q.target_speed_w;
        `OFF_ACCEL_RATE: s_d.rdata = s_q.accel_rate_w;
        `OFF_DECEL_RATE: s_d.rdata = s_q.decel_rate_w;
        `OFF_TORQUE_CEILING: s_d.rdata = s_q.torque_ceiling_w;
        `OFF_FINAL: s_d.rdata = s_q.final_w;
        `OFF_MONSEL_A: s_d.rdata = {24'h00_0000, s_q.monsel_a};
        `OFF_MONSEL_B: s_d.rdata = {24'h00_0000, s_q.monsel_b};
        `OFF_STAT: s_d.rdata = {20'h0_0000, s_q.alarm, 6'h00, s_q.cancel_cmp, s_q.ready};
        `OFF_IO: s_d.rdata = {29'h0000_0000, s_q.in_position, s_q.distribution_done, s_q.latch_done};
        `OFF_MON_A: s_d.rdata = monitor_word(s_q.monsel_a, s_q);
        `OFF_MON_B: s_d.rdata = monitor_word(s_q.monsel_b, s_q);
        `OFF_IRQ_STAT: s_d.rdata = {27'h000_0000, s_q.irq_stat};
        `OFF_IRQ_EN: s_d.rdata = {27'h000_0000, s_q.irq_en};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Motion engine.
    case (s_q.fsm)
      ST_IDLE: s_d.vel = 32'h0000_0000;
      ST_MOVE_FIRST, ST_MOVE_FINAL: begin
        if (s_q.vel < s_q.spd_eff) begin
          s_d.vel = (s_q.spd_eff - s_q.vel > s_q.acc_eff) ? s_q.vel + s_q.acc_eff : s_q.spd_eff;
        end
        s_d.pos = step_toward(s_q.pos, s_q.tgt, s_q.vel);
        if (s_q.fsm == ST_MOVE_FIRST && s_q.latch_req && latch_edge) begin
          s_d.latched = s_q.pos;
          s_d.latch_done = 1'b1;
          irq_set[`IRQ_LATCH] = 1'b1;
          s_d.tgt = 32'(s_q.pos + s_q.final_w);
          s_d.pos = s_q.pos;
          s_d.fsm = ST_MOVE_FINAL;
        end else if (s_q.pos == s_q.tgt) begin
          s_d.distribution_done = 1'b1;
          irq_set[`IRQ_DEN] = 1'b1;
          s_d.vel = 32'h0000_0000;
          s_d.settle_cnt = SETTLE_COUNT;
          s_d.fsm = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (s_q.settle_cnt <= 8'h01) begin
          s_d.in_position = 1'b1;
          s_d.fsm = ST_IDLE;
        end else begin
          s_d.settle_cnt = s_q.settle_cnt - 8'h01;
        end
      end
      default: s_d.fsm = ST_IDLE;
    endcase
    // An abort outranks normal motion; only a running command can be aborted.
    if (s_q.cancel && busy) begin
      s_d.fsm = ST_IDLE;
      s_d.vel = 32'h0000_0000;
      s_d.tgt = s_q.pos;
      s_d.pos = s_q.pos;
      s_d.resp_code = `CMD_CODE_EXTERNAL_POSITIONING_CMD;
      s_d.ready = 1'b1;
      s_d.cancel_cmp = 1'b1;
      s_d.latch_done = s_q.latch_done;
      s_d.distribution_done = s_q.distribution_done;
      irq_set[`IRQ_CANCEL] = 1'b1;
    end
    // Command acceptance and parameter checks.
    if (accept_cmd) begin
      s_d.resp_code = `CMD_CODE_EXTERNAL_POSITIONING_CMD;
      s_d.ready = 1'b1;
      s_d.cancel_cmp = 1'b0;
      irq_set[`IRQ_READY] = 1'b1;
      if (!servo_on_in) begin
        s_d.alarm = `ALM_SERVO_OFF;
        irq_set[`IRQ_ALARM] = 1'b1;
      end else if (s_q.target_speed_w > SPEED_MAX) begin
        s_d.alarm = `ALM_BAD_SPEED;
        irq_set[`IRQ_ALARM] = 1'b1;
      end else begin
        s_d.alarm = `ALM_NONE;
        s_d.acc_eff = acc_pick[31:0];
        s_d.dec_eff = dec_pick[31:0];
        s_d.spd_eff = s_q.target_speed_w;
        s_d.torque_ceiling_eff = (s_q.torque_ceiling_w > TORQUE_MAX) ? TORQUE_MAX : s_q.torque_ceiling_w;
        if (acc_pick[32] | dec_pick[32] | (s_q.torque_ceiling_w > TORQUE_MAX)) begin
          s_d.alarm = `ALM_CLAMPED;
          irq_set[`IRQ_ALARM] = 1'b1;
        end
        s_d.tgt = s_q.target_position_w;
        s_d.fsm = ST_MOVE_FIRST;
        s_d.latch_done = 1'b0;
        s_d.distribution_done = 1'b0;
        s_d.in_position = 1'b0;
      end
    end
    // Speed above the new ceiling is shed at the deceleration rate.
    if (busy && s_q.vel > s_q.spd_eff) begin
      s_d.vel = (s_q.vel - s_q.spd_eff > s_q.dec_eff) ? s_q.vel - s_q.dec_eff : s_q.spd_eff;
    end
    // A new event wins over a clear in the same cycle.
    s_d.irq_stat = s_d.irq_stat | irq_set;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.fsm <= ST_IDLE;
      s_q.torque_ceiling_w <= TORQUE_MAX;
      s_q.torque_ceiling_eff <= TORQUE_MAX;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  property p_accept_echo;
    accept_cmd |=> (s_q.resp_code == 8'h39) && s_q.ready;
  endproperty
  a_accept_echo: assert property (p_accept_echo) else $error("accept did not echo code");

  property p_den_then_in_position;
    $rose(s_q.distribution_done) |-> s_q.fsm == ST_SETTLE ##[1:8] s_q.in_position;
  endproperty
  a_den_then_in_position: assert property (p_den_then_in_position) else $error("in_position did not follow den");

  property p_cancel;
    (s_q.cancel && busy && !accept_cmd) |=> s_q.cancel_cmp && s_q.fsm == ST_IDLE && s_q.ready;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel not completed");

  property p_servo_off;
    (accept_cmd && !servo_on_in) |=> s_q.alarm == 4'hA && s_q.fsm == $past(s_q.fsm);
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("servo off command ran");

  property p_bad_speed;
    (accept_cmd && servo_on_in && s_q.target_speed_w > SPEED_MAX) |=> s_q.alarm == 4'h9;
  endproperty
  a_bad_speed: assert property (p_bad_speed) else $error("bad speed not flagged");

  property p_zero_rate;
    (accept_cmd && servo_on_in && s_q.target_speed_w <= SPEED_MAX && s_q.accel_rate_w == 32'h0)
      |=> s_q.acc_eff == $past(s_q.acc_eff);
  endproperty
  a_zero_rate: assert property (p_zero_rate) else $error("zero accel changed rate");

  property p_clamp;
    (accept_cmd && servo_on_in && s_q.target_speed_w <= SPEED_MAX && s_q.torque_ceiling_w > TORQUE_MAX)
      |=> s_q.alarm == 4'h1 && s_q.torque_ceiling_eff == TORQUE_MAX && s_q.fsm == ST_MOVE_FIRST;
  endproperty
  a_clamp: assert property (p_clamp) else $error("torque not clamped");

  property p_latch;
    (s_q.fsm == ST_MOVE_FIRST && s_q.latch_req && latch_edge && !s_q.cancel && !accept_cmd)
      |=> s_q.latch_done && s_q.tgt == $past(s_q.pos) + $past(s_q.final_w);
  endproperty
  a_latch: assert property (p_latch) else $error("latch target wrong");

  c_latched_move: cover property ($rose(s_q.latch_done) ##[1:300] $rose(s_q.in_position));
  c_plain_move: cover property ((s_q.fsm == ST_MOVE_FIRST) ##[1:300] $rose(s_q.distribution_done));
  c_cancel: cover property ($rose(s_q.cancel_cmp));
endmodule // ext_posing
`default_nettype wire

// ==== ext_posing_defines.svh ====
// Register offsets, field positions, alarm codes, interrupt bits and timing counts of the external positioning block.
`ifndef EXT_POSING_DEFINES_SVH
`define EXT_POSING_DEFINES_SVH
`define CMD_CODE_EXTERNAL_POSITIONING_CMD 8'h39
`define OFF_CMD 8'h00
`define OFF_CTRL 8'h04
`define OFF_TARGET_POSITION 8'h08
`define OFF_TARGET_SPEED 8'h0C
`define OFF_ACCEL_RATE 8'h10
`define OFF_DECEL_RATE 8'h14
`define OFF_TORQUE_CEILING 8'h18
`define OFF_FINAL 8'h1C
`define OFF_MONSEL_A 8'h20
`define OFF_MONSEL_B 8'h24
`define OFF_STAT 8'h28
`define OFF_IO 8'h2C
`define OFF_MON_A 8'h30
`define OFF_MON_B 8'h34
`define OFF_IRQ_STAT 8'h38
`define OFF_IRQ_EN 8'h3C
`define OFF_IRQ_CLR 8'h40
`define CTRL_CANCEL 0
`define CTRL_LATCH_REQ 1
`define CTRL_LATCH_SEL_LO 2
`define STAT_READY 0
`define STAT_CANCEL_CMP 1
`define STAT_ALARM_LO 8
`define IO_LATCH_DONE 0
`define IO_DEN 1
`define IO_IN_POSITION 2
`define ALM_NONE 4'h0
`define ALM_CLAMPED 4'h1
`define ALM_BAD_SPEED 4'h9
`define ALM_SERVO_OFF 4'hA
`define IRQ_READY 0
`define IRQ_LATCH 1
`define IRQ_DEN 2
`define IRQ_CANCEL 3
`define IRQ_ALARM 4
`define SETTLE_TIME_NS 500
`define CLK_PERIOD_NS 100
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== ext_posing_pkg.sv ====
// Types shared by the external positioning block.
package ext_posing_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MOVE_FIRST = 4'b0010,
    ST_MOVE_FINAL = 4'b0100,
    ST_SETTLE = 4'b1000
  } motion_state_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic signed [31:0] position;
    logic [31:0] velocity;
    logic [31:0] torque;
  } drive_ref_t;

  typedef struct packed {
    motion_state_t fsm;
    logic signed [31:0] pos;
    logic signed [31:0] tgt;
    logic signed [31:0] latched;
    logic [31:0] vel;
    logic [31:0] acc_eff;
    logic [31:0] dec_eff;
    logic [31:0] torque_ceiling_eff;
    logic [31:0] spd_eff;
    logic signed [31:0] target_position_w;
    logic [31:0] target_speed_w;
    logic [31:0] accel_rate_w;
    logic [31:0] decel_rate_w;
    logic [31:0] torque_ceiling_w;
    logic signed [31:0] final_w;
    logic cancel;
    logic latch_req;
    logic [1:0] latch_sel;
    logic [7:0] monsel_a;
    logic [7:0] monsel_b;
    logic [7:0] resp_code;
    logic ready;
    logic cancel_cmp;
    logic [3:0] alarm;
    logic latch_done;
    logic distribution_done;
    logic in_position;
    logic [4:0] irq_stat;
    logic [4:0] irq_en;
    logic latch_prev;
    logic [7:0] settle_cnt;
    logic ack;
    logic [31:0] rdata;
  } ext_state_t;
endpackage

// ==== fieldbus_master_model.sv ====
// Fieldbus master model that reaches the positioning block over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_model
  import ext_posing_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic waitrequest_in,
  input wire logic [31:0] readdata_in,
  output ext_posing_pkg::bus_req_t bus_out
);
  initial begin
    bus_out <= '0;
  end

  // Words go out raw: signed position, unsigned speed, rates and torque, latch fields in ctrl.
  task automatic access(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
    @(posedge core_clk_in);
    bus_out.address <= addr;
    bus_out.writedata <= wdata;
    bus_out.write <= wr;
    bus_out.read <= !wr;
    @(posedge core_clk_in);
    // The bench timeout ends a wait that never finishes.
    while (waitrequest_in !== 1'b0) begin
      @(posedge core_clk_in);
    end
    rdata = readdata_in;
    bus_out.read <= 1'b0;
    bus_out.write <= 1'b0;
  endtask
endmodule // fieldbus_master_model
`default_nettype wire

// ==== external_input_positioning_tb.sv ====
// Self-checking testbench of the external positioning block.
`timescale 1ns/100ps
`default_nettype none
`include "ext_posing_defines.svh"
module external_input_positioning_tb;
  import ext_posing_pkg::*;
  localparam logic [31:0] TMAX = 32'h0000_FFFF;
  localparam logic [31:0] SMAX = 32'h0010_0000;
  localparam logic [31:0] AMAX = 32'h0001_0000;
  localparam logic [31:0] C_SP [5] = '{32'hA, SMAX + 32'h1, 32'hA, 32'hA, 32'hA};
  localparam logic [31:0] C_AC [5] = '{32'h2, 32'h2, AMAX + 32'h1, 32'h2, 32'h0};
  localparam logic [31:0] C_TL [5] = '{TMAX, TMAX, TMAX, TMAX + 32'h1, TMAX};
  localparam logic [3:0] C_ALM [5] = '{4'hA, 4'h9, 4'h1, 4'h1, 4'h0};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic servo_on = 1'b1;
  logic [3:0] latch_sig = 4'h0;
  bus_req_t bus_req;
  logic waitreq;
  logic [31:0] rdata;
  drive_ref_t dref;
  logic irq;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  always #50 core_clk = ~core_clk;

  ext_posing #(.SPEED_MAX(SMAX), .ACCEL_MAX(AMAX), .TORQUE_MAX(TMAX)) i_dut (
    .core_clk_in(core_clk), .reset_in(reset), .bus_in(bus_req),
    .bus_waitrequest_out(waitreq), .bus_readdata_out(rdata), .servo_on_in(servo_on),
    .latch_signals_in(latch_sig), .drive_ref_out(dref), .irq_out(irq));

  fieldbus_master_model i_master (
    .core_clk_in(core_clk), .waitrequest_in(waitreq), .readdata_in(rdata), .bus_out(bus_req));

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_master.access(a, 1'b1, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_master.access(a, 1'b0, 32'h0, d);
  endtask

  task automatic start(input logic [31:0] tp, sp, ac, tl, fin, ctl);
    wr(`OFF_TARGET_POSITION, tp);
    wr(`OFF_TARGET_SPEED, sp);
    wr(`OFF_ACCEL_RATE, ac);
    wr(`OFF_DECEL_RATE, ac);
    wr(`OFF_TORQUE_CEILING, tl);
    wr(`OFF_FINAL, fin);
    wr(`OFF_CTRL, ctl);
    wr(`OFF_CMD, {24'h0, `CMD_CODE_EXTERNAL_POSITIONING_CMD});
  endtask

  task automatic chk_resp(input logic [3:0] alm, input logic cc);
    logic [31:0] v;
    rd(`OFF_CMD, v);
    chk_word(v, {24'h0, `CMD_CODE_EXTERNAL_POSITIONING_CMD});
    rd(`OFF_STAT, v);
    chk_word(v, {20'h0, alm, 6'h0, cc, 1'b1});
  endtask

  // Polls the io word; a polled status read is three cycles, so the cap is generous.
  task automatic wait_in_position(input logic [2:0] exp_io);
    logic [31:0] v;
    int n;
    n = 0;
    v = '0;
    while (v[`IO_IN_POSITION] !== 1'b1 && n < 500) begin
      rd(`OFF_IO, v);
      n++;
    end
    chk_word({29'h0, v[2:0]}, {29'h0, exp_io});
  endtask

  task automatic t_reset();
    logic [31:0] v;
    rd(`OFF_STAT, v);
    chk_word(v, 32'h0);
    rd(`OFF_IO, v);
    chk_word(v, 32'h0);
    chk_word(dref.torque, TMAX);
    rd(8'h7C, v);
    chk_word(v, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_no_latch();
    logic [31:0] v;
    wr(`OFF_IRQ_EN, 32'h1F);
    start(32'd100, 32'd10, 32'd2, TMAX, 32'h0, 32'h2);
    chk_resp(4'h0, 1'b0);
    wait_in_position(3'b110);
    chk_word(dref.position, 32'd100);
    chk_word(dref.velocity, 32'h0);
    chk_bit(irq, 1'b1);
    rd(`OFF_IRQ_STAT, v);
    chk_word(v, 32'h05);
    wr(`OFF_IRQ_CLR, 32'h1F);
    rd(`OFF_IRQ_STAT, v);
    chk_word(v, 32'h0);
    chk_bit(irq, 1'b0);
    wr(`OFF_IRQ_EN, 32'h0);
    $display("test no_latch done");
  endtask

  task automatic t_latch();
    logic [31:0] lp;
    logic [31:0] p;
    wr(`OFF_MONSEL_A, 32'h2);
    wr(`OFF_MONSEL_B, 32'h0);
    start(32'd1000, 32'd10, 32'd2, TMAX, 32'hFFFF_FFCE, 32'hA);
    repeat (30) @(posedge core_clk);
    latch_sig <= 4'h4;
    wait_in_position(3'b111);
    latch_sig <= 4'h0;
    rd(`OFF_MON_A, lp);
    rd(`OFF_MON_B, p);
    chk_bit($signed(lp) > 0 && $signed(lp) < 1000, 1'b1);
    chk_word(p, lp - 32'd50);
    chk_word(dref.position, p);
    $display("test latch done");
  endtask

  // Refused commands must leave the position alone; clamped ones still run to target.
  task automatic t_alarms();
    logic [31:0] p0;
    for (int i = 0; i < 5; i++) begin
      servo_on <= (i != 0);
      p0 = dref.position;
      start(32'd2000 + i, C_SP[i], C_AC[i], C_TL[i], 32'h0, 32'h0);
      chk_resp(C_ALM[i], 1'b0);
      if (i < 2) begin
        repeat (20) @(posedge core_clk);
        chk_word(dref.position, p0);
      end else begin
        wait_in_position(3'b110);
        chk_word(dref.position, 32'd2000 + i);
      end
      if (i == 3) begin
        chk_word(dref.torque, TMAX);
      end
    end
    servo_on <= 1'b1;
    $display("test alarms done");
  endtask

  task automatic t_cancel();
    logic [31:0] v;
    logic [31:0] p1;
    start(32'd100000, 32'd1, 32'd1, TMAX, 32'h0, 32'h0);
    repeat (10) @(posedge core_clk);
    chk_word(dref.velocity, 32'h1);
    wr(`OFF_CTRL, 32'h1);
    chk_resp(4'h0, 1'b1);
    p1 = dref.position;
    repeat (10) @(posedge core_clk);
    chk_word(dref.position, p1);
    chk_word(dref.velocity, 32'h0);
    rd(`OFF_IRQ_STAT, v);
    chk_bit(v[`IRQ_CANCEL], 1'b1);
    chk_bit(irq, 1'b0);
    wr(`OFF_CTRL, 32'h0);
    $display("test cancel done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_no_latch();
    t_latch();
    t_alarms();
    t_cancel();
    wrap_up();
  end
endmodule // external_input_positioning_tb
`default_nettype wire
